// ---- design/csr_chip_settings.sv ----
// chip settings register: low byte from eeprom, option rom control, oversize frame
// enables, phy capability, strap-forced setup and sleep-state reset bypass
// assumes a host register port on clk_i, an eeprom loader pulsing once after reset,
// pci reset and strap pins arriving asynchronously
`timescale 1ns/10ps
`include "csr_regs.svh"

module csr_chip_settings #(
   parameter logic [15:0] VENDOR_ID_NORMAL = 16'h1234, // arbitrary value
   parameter logic [15:0] DEVICE_ID_NORMAL = 16'h0001, // arbitrary value
   parameter logic [15:0] VENDOR_ID_ALT = 16'h1235, // arbitrary value
   parameter logic [15:0] DEVICE_ID_ALT = 16'h0002 // arbitrary value
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // host register port
   input wire logic [`CSR_ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [3:0] reg_be_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // eeprom auto-load of the low byte
   input wire logic ee_load_valid_i,
   input wire logic [7:0] ee_load_data_i,
   // strap pins
   input wire logic [`CSR_STRAP_W-1:0] strap_pins_i,
   // option rom window
   input wire logic rom_rd_i,
   input wire logic rom_wr_i,
   input wire logic [31:0] rom_rdata_i,
   output logic [31:0] rom_rdata_o,
   output logic rom_rvalid_o,
   output logic rom_wr_o,
   output logic rom_size_64k_o,
   // frame size controls
   output logic oversize_transmit_enable_o,
   output logic oversize_receive_enable_o,
   // configuration identity
   output logic alt_id_select_o,
   output logic [15:0] vendor_id_o,
   output logic [15:0] device_id_o,
   // power state reset gating
   input wire logic pci_rst_n_i,
   input wire logic power_state_d3_i,
   output logic core_reset_req_o
);

   // stored fields
   logic option_rom_size_select_q;
   logic oversize_transmit_enable_q;
   logic oversize_receive_enable_q;
   logic option_rom_bypass_q;
   logic [2:0] phy_caps_q; // fiber, hundred, ten
   logic sleep_state_reset_bypass_q;
   csr_pkg::csr_forced_t strap_forced_setup;
   logic strap_done;

   // read data and rom answer
   logic [31:0] rdata_q;
   logic rvalid_q;
   logic [31:0] rom_rdata_q;
   logic rom_rvalid_q;

   // pci reset pin synchroniser
   logic pci_rst_s1_q; // first stage, read only by pci_rst_s2_q
   logic pci_rst_s2_q;

   // decoded strobes
   logic hit;
   logic wr_lo;
   logic wr_hi;
   // low byte reset image; its bits feed the reset branch so sizes match exactly
   localparam logic [7:0] LOW_RST = `CSR_LOW_BYTE_RST;

   // assemble the register image, reserved bits read zero
   function automatic logic [31:0] csr_image(input logic size, input logic txl, input logic rxl,
                                             input logic byp, input logic [2:0] caps,
                                             input logic [2:0] forced, input logic sleep);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[`CSR_ROM_SIZE_BIT] = size;
      v[`CSR_TX_LARGE_BIT] = txl;
      v[`CSR_RX_LARGE_BIT] = rxl;
      v[`CSR_ROM_BYPASS_BIT] = byp;
      v[`CSR_PHY_FIBER_BIT:`CSR_PHY_TEN_BIT] = caps;
      v[`CSR_FORCED_MSB:`CSR_FORCED_LSB] = forced;
      v[`CSR_SLEEP_BYPASS_BIT] = sleep;
      return v;
   endfunction

   // strap capture, once per reset
   csr_strap_latch u_strap (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .strap_pins_i(strap_pins_i),
      .forced_o(strap_forced_setup),
      .done_o(strap_done)
   );

   // address decode; only this one word is mapped here
   always_comb begin
      hit = (reg_addr_i == `CSR_CTRL_OFS);
      wr_lo = reg_wr_i && hit && reg_be_i[0];
      wr_hi = reg_wr_i && hit && reg_be_i[1];
   end

   // low byte: eeprom load wins over a host write in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         option_rom_size_select_q <= LOW_RST[`CSR_ROM_SIZE_BIT];
         oversize_transmit_enable_q <= LOW_RST[`CSR_TX_LARGE_BIT];
         oversize_receive_enable_q <= LOW_RST[`CSR_RX_LARGE_BIT];
         option_rom_bypass_q <= LOW_RST[`CSR_ROM_BYPASS_BIT];
      end else if (ee_load_valid_i) begin
         option_rom_size_select_q <= ee_load_data_i[`CSR_ROM_SIZE_BIT];
         oversize_transmit_enable_q <= ee_load_data_i[`CSR_TX_LARGE_BIT];
         oversize_receive_enable_q <= ee_load_data_i[`CSR_RX_LARGE_BIT];
         option_rom_bypass_q <= ee_load_data_i[`CSR_ROM_BYPASS_BIT];
      end else if (wr_lo) begin
         option_rom_size_select_q <= reg_wdata_i[`CSR_ROM_SIZE_BIT];
         oversize_transmit_enable_q <= reg_wdata_i[`CSR_TX_LARGE_BIT];
         oversize_receive_enable_q <= reg_wdata_i[`CSR_RX_LARGE_BIT];
         option_rom_bypass_q <= reg_wdata_i[`CSR_ROM_BYPASS_BIT];
      end
   end

   // phy capability: only the eeprom can set it; host writes are dropped
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phy_caps_q <= 3'h0;
      end else if (ee_load_valid_i) begin
         phy_caps_q <= ee_load_data_i[`CSR_PHY_FIBER_BIT:`CSR_PHY_TEN_BIT];
      end
   end

   // sleep-state reset bypass, plain read/write
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sleep_state_reset_bypass_q <= `CSR_SLEEP_BYPASS_RST;
      end else if (wr_hi) begin
         sleep_state_reset_bypass_q <= reg_wdata_i[`CSR_SLEEP_BYPASS_BIT];
      end
   end

   // register read, answered one cycle later; unmapped words read zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= reg_rd_i;
         if (reg_rd_i && hit) begin
            rdata_q <= csr_image(option_rom_size_select_q, oversize_transmit_enable_q,
                                 oversize_receive_enable_q, option_rom_bypass_q, phy_caps_q,
                                 strap_forced_setup, sleep_state_reset_bypass_q);
         end else if (reg_rd_i) begin
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   // option rom reads: forced to zero while bypassed, one cycle later
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rom_rdata_q <= 32'h0000_0000;
         rom_rvalid_q <= 1'b0;
      end else begin
         rom_rvalid_q <= rom_rd_i;
         if (rom_rd_i) begin
            rom_rdata_q <= option_rom_bypass_q ? 32'h0000_0000 : rom_rdata_i;
         end
      end
   end

   // pci reset pin is asynchronous to clk_i
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pci_rst_s1_q <= 1'b1;
         pci_rst_s2_q <= 1'b1;
      end else begin
         pci_rst_s1_q <= pci_rst_n_i;
         pci_rst_s2_q <= pci_rst_s1_q;
      end
   end

   // outputs
   assign reg_rdata_o = rdata_q;
   assign reg_rvalid_o = rvalid_q;
   assign rom_rdata_o = rom_rdata_q;
   assign rom_rvalid_o = rom_rvalid_q;
   // writes into the rom window are swallowed while bypassed
   assign rom_wr_o = rom_wr_i && !option_rom_bypass_q;
   assign rom_size_64k_o = option_rom_size_select_q;
   assign oversize_transmit_enable_o = oversize_transmit_enable_q;
   assign oversize_receive_enable_o = oversize_receive_enable_q;
   // only mode 1 swaps identifiers; reserved codes keep the normal ones
   assign alt_id_select_o = (strap_forced_setup == `CSR_FORCED_MODE1);
   assign vendor_id_o = alt_id_select_o ? VENDOR_ID_ALT : VENDOR_ID_NORMAL;
   assign device_id_o = alt_id_select_o ? DEVICE_ID_ALT : DEVICE_ID_NORMAL;
   // the pci reset is blocked in d3 while the sleep bypass bit is set, so wake logic survives a host reboot
   assign core_reset_req_o = !pci_rst_s2_q && !(sleep_state_reset_bypass_q && power_state_d3_i);

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_EEPROM_LOW_BYTE: assert property (
      ee_load_valid_i |=> option_rom_bypass_q == $past(ee_load_data_i[4])
         && rom_size_64k_o == $past(ee_load_data_i[1])
         && oversize_transmit_enable_o == $past(ee_load_data_i[2])
         && oversize_receive_enable_o == $past(ee_load_data_i[3]))
      else $error("eeprom byte not loaded");

   AST_ROM_SIZE_WRITE: assert property (
      (wr_lo && !ee_load_valid_i) |=> rom_size_64k_o == $past(reg_wdata_i[1]))
      else $error("rom size bit not written");

   AST_TX_LARGE_HOLD: assert property (
      (!wr_lo && !ee_load_valid_i) |=> $stable(oversize_transmit_enable_o))
      else $error("oversize transmit changed without write");

   AST_RX_LARGE_WRITE: assert property (
      (wr_lo && !ee_load_valid_i) ##1 !wr_lo && !ee_load_valid_i |=>
         oversize_receive_enable_o == $past(reg_wdata_i[3], 2))
      else $error("oversize receive not kept");

   AST_ROM_READ_ZERO: assert property (
      (rom_rd_i && option_rom_bypass_q) |=> rom_rvalid_o && rom_rdata_o == 32'h0000_0000)
      else $error("rom read not zeroed while bypassed");

   AST_ROM_WRITE_DROP: assert property (
      option_rom_bypass_q |-> !rom_wr_o)
      else $error("rom write passed while bypassed");

   AST_CAPS_READ_ONLY: assert property (
      !ee_load_valid_i |=> $stable(phy_caps_q))
      else $error("phy capability changed by host");

   AST_STRAP_HELD: assert property (
      (strap_done && $past(strap_done)) |-> $stable(strap_forced_setup))
      else $error("strap field changed after capture");

   AST_ALT_ID: assert property (
      (strap_forced_setup == `CSR_FORCED_MODE1) |-> vendor_id_o == VENDOR_ID_ALT && device_id_o == DEVICE_ID_ALT)
      else $error("alternate identifiers not presented");

   AST_D3_BYPASS: assert property (
      (sleep_state_reset_bypass_q && power_state_d3_i) |-> !core_reset_req_o)
      else $error("pci reset passed in d3 with bypass set");

   AST_SLEEP_WRITE: assert property (
      wr_hi |=> sleep_state_reset_bypass_q == $past(reg_wdata_i[11]))
      else $error("sleep bypass bit not written");

   AST_READBACK: assert property (
      (reg_rd_i && hit) |=> reg_rvalid_o && reg_rdata_o[31:12] == 20'h00000 && !reg_rdata_o[0]
         && reg_rdata_o[7:5] == $past(phy_caps_q))
      else $error("register image wrong");

endmodule

// ---- design/csr_strap_latch.sv ----
// strap latch: synchronises the strap pins and captures them once after reset release
// assumes strap pins are static board levels, asynchronous to clk_i
`timescale 1ns/10ps
`include "csr_regs.svh"

module csr_strap_latch (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [`CSR_STRAP_W-1:0] strap_pins_i,
   output csr_pkg::csr_forced_t forced_o,
   output logic done_o
);

   logic [`CSR_STRAP_W-1:0] sync1_q; // first stage, read only by sync2_q
   logic [`CSR_STRAP_W-1:0] sync2_q; // second stage, safe to use
   logic [1:0] settle_q; // edges since release
   csr_pkg::csr_strap_state_t state_q;
   csr_pkg::csr_forced_t forced_q;

   // two-flop synchroniser on the pins
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= strap_pins_i;
         sync2_q <= sync1_q;
      end
   end

   // capture sequencer: wait for the synchroniser to fill, then latch once
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= csr_pkg::CSR_STRAP_SETTLING;
         settle_q <= 2'h0;
      end else begin
         case (state_q)
            csr_pkg::CSR_STRAP_SETTLING: begin
               settle_q <= settle_q + 2'h1;
               if (settle_q == `CSR_STRAP_SETTLE - 2'h1) begin
                  state_q <= csr_pkg::CSR_STRAP_CAPTURE;
               end
            end
            csr_pkg::CSR_STRAP_CAPTURE: begin
               state_q <= csr_pkg::CSR_STRAP_HELD;
            end
            default: begin
               state_q <= csr_pkg::CSR_STRAP_HELD;
            end
         endcase
      end
   end

   // pins are inverted on capture; the value never changes again until reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         forced_q <= `CSR_FORCED_RST;
      end else if (state_q == csr_pkg::CSR_STRAP_CAPTURE) begin
         forced_q <= ~sync2_q;
      end
   end

   assign forced_o = forced_q;
   assign done_o = (state_q == csr_pkg::CSR_STRAP_HELD);

endmodule

// ---- shared/csr_pkg.sv ----
// types shared by the chip settings register and its strap latch
// assumes csr_regs.svh is on the include path
`include "csr_regs.svh"

package csr_pkg;

   // strap latch progress after reset release
   typedef enum logic [1:0] {
      CSR_STRAP_SETTLING,
      CSR_STRAP_CAPTURE,
      CSR_STRAP_HELD
   } csr_strap_state_t;

   // forced configuration field
   typedef logic [`CSR_STRAP_W-1:0] csr_forced_t;

endpackage

// ---- shared/csr_regs.svh ----
// offsets, field positions, reset values and counts of the chip settings register
// assumes inclusion by bare name from design files and the package
`ifndef CSR_REGS_SVH
`define CSR_REGS_SVH

// register offset within the 128-byte i/o window
`define CSR_ADDR_W 7
`define CSR_CTRL_OFS 7'h30

// field positions
`define CSR_RSVD0_BIT 0
`define CSR_ROM_SIZE_BIT 1
`define CSR_TX_LARGE_BIT 2
`define CSR_RX_LARGE_BIT 3
`define CSR_ROM_BYPASS_BIT 4
`define CSR_PHY_TEN_BIT 5
`define CSR_PHY_HUNDRED_BIT 6
`define CSR_PHY_FIBER_BIT 7
`define CSR_FORCED_LSB 8
`define CSR_FORCED_MSB 10
`define CSR_SLEEP_BYPASS_BIT 11
`define CSR_RSVD12_BIT 12

// reset values
`define CSR_LOW_BYTE_RST 8'h00
`define CSR_FORCED_RST 3'h0
`define CSR_SLEEP_BYPASS_RST 1'b0

// forced configuration codes
`define CSR_FORCED_NONE 3'h0
`define CSR_FORCED_MODE1 3'h1

// strap pins, and edges after reset release until synchronised strap levels settle
`define CSR_STRAP_W 3
`define CSR_STRAP_SETTLE 2'h2

`endif

// ---- tb/csr_ee_model.sv ----
// eeprom partner: sends the stored low byte once after reset release and on request
// assumes the same clock and reset as the chip settings register
`timescale 1ns/10ps

module csr_ee_model #(
   parameter int LOAD_DELAY = 6 // cycles from reset release to the auto-load
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic req_i, // extra load on demand
   input wire logic [7:0] byte_i, // byte held in the eeprom
   output logic valid_o,
   output logic [7:0] data_o
);
   logic [3:0] cnt_q; // counts towards the auto-load, then parks
   logic fire; // a load leaves this cycle
   assign fire = (cnt_q == 4'(LOAD_DELAY - 1)) || req_i;
   // auto-load counter, parks at its top so the load happens once
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 4'h0;
      end else if (cnt_q != 4'hf) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   // strobe; data inverted outside it so a stale byte never looks valid
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_o <= 1'b0;
         data_o <= 8'h00;
      end else begin
         valid_o <= fire;
         data_o <= fire ? byte_i : ~data_o;
      end
   end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the chip settings register
// assumes the eeprom model on the load port and straps driven here
`timescale 1ns/10ps
`include "csr_regs.svh"

module testbench;
   logic clk_i = 1'b0, rst_n_i = 1'b0; // clock and async reset
   logic [6:0] reg_addr_i = 7'h00;
   logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, ee_req = 1'b0;
   logic [3:0] reg_be_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0, rom_rdata_i = 32'h0;
   logic [31:0] reg_rdata_o, rom_rdata_o;
   logic reg_rvalid_o, rom_rvalid_o, rom_wr_o, rom_size_64k_o, ee_valid;
   logic rom_rd_i = 1'b0, rom_wr_i = 1'b0, pci_rst_n_i = 1'b1, power_state_d3_i = 1'b0;
   logic otx, orx, alt_id, core_rst;
   logic [15:0] vid, did;
   logic [7:0] ee_data, ee_byte = 8'h61; // bit 0 of the byte is dropped
   logic [2:0] strap_pins_i = 3'b110; // inverted: forced mode 1
   int fails = 0, total_checks = 0;

   csr_ee_model u_csr_ee_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(ee_req), .byte_i(ee_byte),
      .valid_o(ee_valid), .data_o(ee_data));
   csr_chip_settings u_csr_chip_settings (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .ee_load_valid_i(ee_valid),
      .ee_load_data_i(ee_data), .strap_pins_i(strap_pins_i), .rom_rd_i(rom_rd_i), .rom_wr_i(rom_wr_i),
      .rom_rdata_i(rom_rdata_i), .rom_rdata_o(rom_rdata_o), .rom_rvalid_o(rom_rvalid_o),
      .rom_wr_o(rom_wr_o), .rom_size_64k_o(rom_size_64k_o), .oversize_transmit_enable_o(otx),
      .oversize_receive_enable_o(orx), .alt_id_select_o(alt_id), .vendor_id_o(vid),
      .device_id_o(did), .pci_rst_n_i(pci_rst_n_i), .power_state_d3_i(power_state_d3_i),
      .core_reset_req_o(core_rst));

   // 250 MHz clock
   initial begin
      forever #2 clk_i = ~clk_i;
   end

   // compare and count
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask

   // reset pulse of 5 cycles, then straps settle and the eeprom loads
   task automatic do_reset();
      rst_n_i = 1'b0;
      repeat (5) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      repeat (12) @(posedge clk_i);
   endtask

   // one-cycle host write to the register
   task automatic reg_write(input logic [3:0] be, input logic [31:0] d);
      @(posedge clk_i);
      #1 reg_wr_i = 1'b1;
      reg_addr_i = `CSR_CTRL_OFS;
      reg_be_i = be;
      reg_wdata_i = d;
      @(posedge clk_i);
      #1 reg_wr_i = 1'b0;
   endtask

   // one-cycle host read, answer judged in the rvalid cycle
   task automatic reg_read(input logic [6:0] a, input logic [31:0] exp);
      @(posedge clk_i);
      #1 reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(posedge clk_i);
      #1 reg_rd_i = 1'b0;
      check("reg_rvalid", 1, reg_rvalid_o);
      check("reg_rdata", exp, reg_rdata_o);
   endtask

   // rom read and write probe; write gate is combinational
   task automatic rom_probe(input logic [31:0] exp, input logic exp_wr);
      @(posedge clk_i);
      #1 rom_rd_i = 1'b1;
      rom_wr_i = 1'b1;
      rom_rdata_i = 32'hdeadbeef;
      #1 check("rom_wr", exp_wr, rom_wr_o);
      @(posedge clk_i);
      #1 rom_rd_i = 1'b0;
      rom_wr_i = 1'b0;
      check("rom_rvalid", 1, rom_rvalid_o);
      check("rom_rdata", exp, rom_rdata_o);
   endtask

   // read/write fields, read-only fields kept, reserved bits 31:13 written as ones, bits 31:12 read as zero
   task automatic t_fields();
      reg_write(4'hf, 32'hffffef1e);
      reg_read(`CSR_CTRL_OFS, 32'h0000097e);
      check("tx_large", 1, otx);
      check("rx_large", 1, orx);
      check("rom_64k", 1, rom_size_64k_o);
      reg_read(7'h34, 32'h0);
   endtask

   // sleep-state bypass holds pci reset off only in d3
   task automatic t_sleep();
      pci_rst_n_i = 1'b0;
      power_state_d3_i = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 check("core_rst_d3", 0, core_rst);
      power_state_d3_i = 1'b0;
      #1 check("core_rst_d0", 1, core_rst);
      @(posedge clk_i);
      #1 pci_rst_n_i = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 check("core_rst_idle", 0, core_rst);
      reg_write(4'h2, 32'h0);
      reg_read(`CSR_CTRL_OFS, 32'h0000017e);
      // bypass cleared: pci reset passes even in d3
      pci_rst_n_i = 1'b0;
      power_state_d3_i = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 check("core_rst_d3_nobyp", 1, core_rst);
      @(posedge clk_i);
      #1 pci_rst_n_i = 1'b1;
      power_state_d3_i = 1'b0;
      repeat (4) @(posedge clk_i);
   endtask

   // option rom bypass zeroes reads and drops writes
   task automatic t_rom();
      rom_probe(32'h0, 1'b0);
      reg_write(4'h1, 32'h0000000e);
      rom_probe(32'hdeadbeef, 1'b1);
   endtask

   // capability patterns arrive from the eeprom only
   task automatic t_caps();
      logic [2:0] codes [3];
      codes = '{3'b001, 3'b011, 3'b111};
      foreach (codes[i]) begin
         ee_byte = {codes[i], 5'h00};
         @(posedge clk_i);
         #1 ee_req = 1'b1;
         @(posedge clk_i);
         #1 ee_req = 1'b0;
         repeat (2) @(posedge clk_i);
         reg_read(`CSR_CTRL_OFS, {24'h000001, codes[i], 5'h00});
      end
   endtask

   // close the run
   task automatic give_verdict();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      do_reset();
      reg_read(`CSR_CTRL_OFS, 32'h00000160);
      check("alt_id", 1, alt_id);
      check("vendor_alt", 16'h1235, vid);
      check("device_alt", 16'h0002, did);
      t_fields();
      t_sleep();
      t_rom();
      t_caps();
      ee_byte = 8'h21;
      strap_pins_i = 3'b111;
      reg_write(4'h2, 32'h00000800);
      do_reset();
      reg_read(`CSR_CTRL_OFS, 32'h00000020);
      check("vendor_norm", 16'h1234, vid);
      check("device_norm", 16'h0001, did);
      check("alt_id_off", 0, alt_id);
      give_verdict();
   end

   // watchdog: the tests take under a hundred cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      fails++;
      give_verdict();
   end
endmodule
